/* rtl/amr_defines.vh */
// amr_defines.vh: opcode patterns, field widths, irq enable bit position and reset values
// assumes: included by the decode/execute block and its file-write memory
`ifndef AMR_DEFINES_VH
`define AMR_DEFINES_VH

// ----------------------------------------
// instruction word layout
// ----------------------------------------
`define AMR_OP_W 14
`define AMR_DATA_W 8
`define AMR_FADDR_W 7
`define AMR_PC_W 13
`define AMR_FILE_DEPTH 128

// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define AMR_STORE_MASK 14'h3F80
`define AMR_STORE_PAT 14'h0080
`define AMR_LOADLIT_MASK 14'h3C00
`define AMR_LOADLIT_PAT 14'h3000
`define AMR_NOP_MASK 14'h3F9F
`define AMR_NOP_PAT 14'h0000
`define AMR_RETIRQ_PAT 14'h0009

// ----------------------------------------
// irq control register and accumulator reset values
// ----------------------------------------
`define AMR_IRQ_EN_BIT 7
`define AMR_IRQCTL_RST 8'h00
`define AMR_ACC_RST 8'h00

`endif

/* rtl/amr_file_mem.v */
// amr_file_mem.v: 128 x 8 file register storage
// assumes: single clock; one write port, one registered read port
`timescale 1ns/1ps
`include "amr_defines.vh"

module amr_file_mem (
    // clock
    input wire i_clk,
    // write port
    input wire i_we,
    input wire [`AMR_FADDR_W-1:0] i_waddr,
    input wire [`AMR_DATA_W-1:0] i_wdata,
    // read port
    input wire [`AMR_FADDR_W-1:0] i_raddr,
    output reg [`AMR_DATA_W-1:0] o_rdata
);

    reg [`AMR_DATA_W-1:0] mem [0:`AMR_FILE_DEPTH-1];

    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end

endmodule // amr_file_mem

/* rtl/amr_decode_exec.v */
// amr_decode_exec.v: four-phase decode/execute for store, load-literal, nop, return-from-irq
// assumes: i_instr stable while o_fetch_ready low; stack and pc live outside
`timescale 1ns/1ps
`include "amr_defines.vh"

module amr_decode_exec (
    // clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // instruction in
    input wire [`AMR_OP_W-1:0] i_instr,
    // stack interface
    input wire [`AMR_PC_W-1:0] i_stack_top,
    output wire o_stack_pop,
    // program counter load
    output reg o_pc_load,
    output reg [`AMR_PC_W-1:0] o_pc_value,
    // instruction cycle status
    output wire o_fetch_ready,
    output wire [3:0] o_phase,
    // architectural state
    output reg [`AMR_DATA_W-1:0] o_accumulator,
    output reg [`AMR_DATA_W-1:0] o_irq_control_reg,
    output wire o_global_irq_enable,
    // file register read-back
    input wire [`AMR_FADDR_W-1:0] i_file_raddr,
    output wire [`AMR_DATA_W-1:0] o_file_rdata,
    // decoded instruction kind
    output reg o_illegal
);

    // ----------------------------------------
    // phase states, one-hot
    // ----------------------------------------
    localparam PH_Q1 = 4'b0001;
    localparam PH_Q2 = 4'b0010;
    localparam PH_Q3 = 4'b0100;
    localparam PH_Q4 = 4'b1000;

    reg [3:0] phase_r;
    reg [3:0] phase_nxt;
    reg [`AMR_OP_W-1:0] instr_r;
    reg idle_cycle_r;
    reg idle_cycle_nxt;
    reg [`AMR_OP_W-1:0] instr_nxt;
    reg [`AMR_DATA_W-1:0] acc_nxt;
    wire [`AMR_DATA_W-1:0] irq_ctl_nxt;
    reg pc_load_nxt;
    reg [`AMR_PC_W-1:0] pc_value_nxt;
    reg illegal_nxt;

    // ----------------------------------------
    // phase sequencer
    // ----------------------------------------
    always @* begin
        case (phase_r)
            PH_Q1: phase_nxt = PH_Q2;
            PH_Q2: phase_nxt = PH_Q3;
            PH_Q3: phase_nxt = PH_Q4;
            PH_Q4: phase_nxt = PH_Q1;
            default: phase_nxt = PH_Q1;
        endcase
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire is_store = ((instr_r & `AMR_STORE_MASK) == `AMR_STORE_PAT);
    wire is_loadlit = ((instr_r & `AMR_LOADLIT_MASK) == `AMR_LOADLIT_PAT);
    wire is_nop = ((instr_r & `AMR_NOP_MASK) == `AMR_NOP_PAT);
    wire is_retirq = (instr_r == `AMR_RETIRQ_PAT);
    wire active = ~idle_cycle_r;
    wire [`AMR_FADDR_W-1:0] faddr = instr_r[`AMR_FADDR_W-1:0];
    wire [`AMR_DATA_W-1:0] literal = instr_r[`AMR_DATA_W-1:0];

    wire in_q4 = (phase_r == PH_Q4);
    wire file_we = active & is_store & in_q4;
    wire acc_we = active & is_loadlit & in_q4;
    wire irq_en_set = active & is_retirq & (phase_r == PH_Q3);
    assign o_stack_pop = active & is_retirq & in_q4;

    // second cycle of return is idle
    always @* begin
        idle_cycle_nxt = idle_cycle_r;
        if (in_q4) begin
            idle_cycle_nxt = active & is_retirq;
        end
    end

    assign o_fetch_ready = in_q4 & ~(active & is_retirq);
    assign o_phase = phase_r;
    assign o_global_irq_enable = o_irq_control_reg[`AMR_IRQ_EN_BIT];

    // ----------------------------------------
    // instruction register next value
    // ----------------------------------------
    always @* begin
        instr_nxt = instr_r;
        if (o_fetch_ready) begin
            instr_nxt = i_instr;
        end else if (in_q4) begin
            instr_nxt = `AMR_NOP_PAT;
        end
    end

    // ----------------------------------------
    // accumulator next value
    // ----------------------------------------
    always @* begin
        acc_nxt = o_accumulator;
        if (acc_we) begin
            acc_nxt = literal;
        end
    end

    // ----------------------------------------
    // irq control next value, per bit
    // ----------------------------------------
    genvar bit_i;
    generate
        for (bit_i = 0; bit_i < `AMR_DATA_W; bit_i = bit_i + 1) begin : irq_ctl_bit
            if (bit_i == `AMR_IRQ_EN_BIT) begin : enable_bit
                assign irq_ctl_nxt[bit_i] = o_irq_control_reg[bit_i] | irq_en_set;
            end else begin : plain_bit
                assign irq_ctl_nxt[bit_i] = o_irq_control_reg[bit_i];
            end
        end
    endgenerate

    // ----------------------------------------
    // program counter load next value
    // ----------------------------------------
    always @* begin
        pc_load_nxt = o_stack_pop;
    end

    always @* begin
        pc_value_nxt = o_pc_value;
        if (o_stack_pop) begin
            pc_value_nxt = i_stack_top;
        end
    end

    // ----------------------------------------
    // illegal decode next value
    // ----------------------------------------
    always @* begin
        illegal_nxt = o_illegal;
        if (phase_r == PH_Q1) begin
            illegal_nxt = active & ~(is_store | is_loadlit | is_nop | is_retirq);
        end
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_r <= PH_Q1;
            instr_r <= `AMR_NOP_PAT;
            idle_cycle_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            idle_cycle_r <= idle_cycle_nxt;
            instr_r <= instr_nxt;
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_accumulator <= `AMR_ACC_RST;
        end else begin
            o_accumulator <= acc_nxt;
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq_control_reg <= `AMR_IRQCTL_RST;
        end else begin
            o_irq_control_reg <= irq_ctl_nxt;
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pc_load <= 1'b0;
            o_pc_value <= {`AMR_PC_W{1'b0}};
        end else begin
            o_pc_load <= pc_load_nxt;
            o_pc_value <= pc_value_nxt;
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_illegal <= 1'b0;
        end else begin
            o_illegal <= illegal_nxt;
        end
    end

    // ----------------------------------------
    // file registers
    // ----------------------------------------
    amr_file_mem u_file (
        .i_clk(i_clk),
        .i_we(file_we),
        .i_waddr(faddr),
        .i_wdata(o_accumulator),
        .i_raddr(i_file_raddr),
        .o_rdata(o_file_rdata)
    );

endmodule // amr_decode_exec

/* tb/amr_decode_exec_asserts.sv */
// amr_decode_exec_asserts.sv: phase and return checks
// assumes: bound into amr_decode_exec
`timescale 1ns/1ps
module amr_chk (
    input wire i_clk,
    input wire i_arst_n,
    input wire [12:0] i_stack_top,
    input wire o_stack_pop,
    input wire o_pc_load,
    input wire [12:0] o_pc_value,
    input wire o_fetch_ready,
    input wire [3:0] o_phase,
    input wire [7:0] o_accumulator,
    input wire [7:0] o_irq_control_reg,
    input wire o_global_irq_enable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence ret_done;
        ##4 o_phase == 4'h8 && o_fetch_ready;
    endsequence
    phase_hot_a: assert property ($onehot(o_phase)) else $error("phase not one-hot");
    phase_wrap_a: assert property (o_phase == 4'h8 |=> o_phase == 4'h1) else $error("no wrap");
    pop_q4_a: assert property (o_stack_pop |-> o_phase == 4'h8 && !o_fetch_ready && o_global_irq_enable)
        else $error("pop out of place");
    pc_load_a: assert property (o_stack_pop |=> o_pc_load && o_pc_value == $past(i_stack_top))
        else $error("pc not loaded");
    pc_cause_a: assert property (o_pc_load |-> $past(o_stack_pop)) else $error("stray pc load");
    irq_en_rise_a: assert property ($rose(o_global_irq_enable) |-> o_phase == 4'h8) else $error("enable late");
    irq_en_bit_a: assert property (o_global_irq_enable == o_irq_control_reg[7] && o_irq_control_reg[6:0] == 7'h00)
        else $error("enable bit");
    acc_q4_a: assert property ($changed(o_accumulator) |-> o_phase == 4'h1) else $error("acc write");
    ret_two_a: assert property (o_stack_pop |-> ret_done) else $error("return length");
endmodule // amr_chk
bind amr_decode_exec amr_chk amr_chk_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_stack_top(i_stack_top),
    .o_stack_pop(o_stack_pop), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_fetch_ready(o_fetch_ready),
    .o_phase(o_phase), .o_accumulator(o_accumulator), .o_irq_control_reg(o_irq_control_reg),
    .o_global_irq_enable(o_global_irq_enable));

/* tb/amr_decode_exec_tb.sv */
// amr_decode_exec_tb.sv: table of moves, then store, return and reset cases
// assumes: 25 MHz clock, design under rtl/
`timescale 1ns/1ps
module amr_decode_exec_tb;
    reg i_clk = 1'b0, i_arst_n = 1'b0;
    reg [13:0] i_instr = 14'h0000;
    reg [12:0] i_stack_top = 13'h0000;
    reg [6:0] i_file_raddr = 7'h00;
    wire o_stack_pop, o_pc_load, o_fetch_ready, o_global_irq_enable, o_illegal;
    wire [12:0] o_pc_value;
    wire [3:0] o_phase;
    wire [7:0] o_accumulator, o_irq_control_reg, o_file_rdata;
    int err_total = 0, samples_checked = 0, i, n;
    reg [21:0] rows [0:5] = '{{14'h3055, 8'h55}, {14'h33AA, 8'hAA}, {14'h0060, 8'hAA},
        {14'h3100, 8'h00}, {14'h0000, 8'h00}, {14'h32FF, 8'hFF}};
    amr_decode_exec amr_decode_exec_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_instr(i_instr),
        .i_stack_top(i_stack_top), .o_stack_pop(o_stack_pop), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
        .o_fetch_ready(o_fetch_ready), .o_phase(o_phase), .o_accumulator(o_accumulator),
        .o_irq_control_reg(o_irq_control_reg), .o_global_irq_enable(o_global_irq_enable),
        .i_file_raddr(i_file_raddr), .o_file_rdata(o_file_rdata), .o_illegal(o_illegal));
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    task close_out;
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task go(input [13:0] w);
        @(posedge i_clk) i_instr <= w;
        n = 0;
        do begin @(negedge i_clk); n++; end while (!(o_phase === 4'h8 && o_fetch_ready === 1'b1) && n < 20);
        if (n >= 20) begin
            err_total++;
            close_out;
        end
        @(posedge i_clk);
    endtask
    task rd(input [6:0] a, input [7:0] e);
        @(posedge i_clk) i_file_raddr <= a;
        @(posedge i_clk);
        @(negedge i_clk) chk(o_file_rdata, e);
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        @(negedge i_clk) chk({o_phase, o_irq_control_reg}, 12'h100);
        chk(o_accumulator, 8'h00);
        @(posedge i_clk) i_arst_n <= 1'b1;
        for (i = 0; i < 6; i++) begin
            go(rows[i][21:8]);
            go(14'h0000);
            @(negedge i_clk) chk({o_illegal, o_accumulator}, {1'b0, rows[i][7:0]});
        end
        go(14'h0100);
        go(14'h0000);
        @(negedge i_clk) chk({o_illegal, o_accumulator}, 9'h1FF);
        go(14'h00FF);
        go(14'h3012);
        go(14'h0080);
        go(14'h0000);
        rd(7'h7F, 8'hFF);
        rd(7'h00, 8'h12);
        chk(o_global_irq_enable, 1'b0);
        @(posedge i_clk) i_stack_top <= 13'h1ABC;
        go(14'h0009);
        go(14'h3077);
        chk(n[15:0], 16'h0007);
        go(14'h0000);
        @(negedge i_clk) chk(o_pc_value, 13'h1ABC);
        chk({o_irq_control_reg, o_accumulator}, 16'h8077);
        @(posedge i_clk) i_arst_n <= 1'b0;
        @(negedge i_clk) chk({o_phase, o_irq_control_reg}, 12'h100);
        chk(o_pc_value, 13'h0000);
        chk({o_pc_load, o_accumulator}, 9'h000);
        @(posedge i_clk) i_arst_n <= 1'b1;
        go(14'h3033);
        go(14'h0000);
        @(negedge i_clk) chk({o_global_irq_enable, o_accumulator}, 9'h033);
        close_out;
    end
endmodule // amr_decode_exec_tb
